//--- sim/acss_filter_model.sv
// Stand-in for the converter filter that reports finished conversions
`timescale 1ns/1ns
`default_nettype none
module acss_filter_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [3:0] gap,
  output logic done,
  output logic [23:0] raw
);
  logic [3:0] cnt_r;
  logic [23:0] val_r;
  // One result every gap+1 cycles; raw churns between results
  always @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_r <= 4'h0;
      done <= 1'b0;
      raw <= 24'hA5_A5A5;
      val_r <= 24'h12_3456;
    end else begin
      done <= (cnt_r == gap);
      cnt_r <= (cnt_r == gap) ? 4'h0 : cnt_r + 4'h1;
      raw <= (cnt_r == gap) ? val_r : ~raw;
      if (cnt_r == gap) val_r <= val_r + 24'h9A_5A3B;
    end
  end
endmodule
`default_nettype wire

//--- sim/acss_sequencer_checker.sv
// Concurrent checks on the sequencer's register and result ports
`timescale 1ns/1ns
`default_nettype none
module acss_sequencer_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [23:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic CONV_DONE,
  input wire logic [23:0] CONV_RAW,
  input wire logic SEQ_ACTIVE,
  input wire logic [2:0] ACTIVE_CH,
  input wire logic POLARITY,
  input wire logic DATA_VALID,
  input wire logic [2:0] DATA_CH,
  input wire logic [23:0] DATA_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  read_answer_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered next cycle");
  read_cause_a: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("read answer without request");
  unmapped_zero_a: assert property (REG_RD && REG_ADDR == 8'h07 |=> REG_RDATA == 24'h00_0000)
    else $error("unmapped read not zero");
  result_cause_a: assert property (DATA_VALID |-> $past(CONV_DONE) && $past(SEQ_ACTIVE))
    else $error("result without conversion");
  idle_ignore_a: assert property (CONV_DONE && !SEQ_ACTIVE |=> !DATA_VALID)
    else $error("result while not running");
  bipolar_code_a: assert property (DATA_VALID && $past(POLARITY)
    |-> DATA_OUT == {~$past(CONV_RAW[23]), $past(CONV_RAW[22:0])})
    else $error("bipolar coding wrong");
  unipolar_code_a: assert property (DATA_VALID && !$past(POLARITY) |-> DATA_OUT ==
    ($past(CONV_RAW[23]) ? 24'h00_0000 : {$past(CONV_RAW[22:0]), 1'b0}))
    else $error("unipolar coding wrong");
  result_slot_a: assert property (DATA_VALID && !$past(CONV_DONE, 2)
    |-> DATA_CH == $past(ACTIVE_CH))
    else $error("result tagged with wrong slot");
  result_hold_a: assert property (!DATA_VALID |-> $stable(DATA_OUT) && $stable(DATA_CH))
    else $error("result changed without valid");
endmodule
`default_nettype wire
bind acss_sequencer acss_sequencer_checker acss_sequencer_checker_i (.CLK(CLK), .RST_N(RST_N),
  .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .CONV_DONE(CONV_DONE), .CONV_RAW(CONV_RAW), .SEQ_ACTIVE(SEQ_ACTIVE),
  .ACTIVE_CH(ACTIVE_CH), .POLARITY(POLARITY), .DATA_VALID(DATA_VALID),
  .DATA_CH(DATA_CH), .DATA_OUT(DATA_OUT));

//--- sim/tb_acss_sequencer.sv
// Register and sequencing tests for the channel/setup sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_acss_sequencer;
  logic CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, run = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [23:0] REG_WDATA = 24'h00_0000, REG_RDATA, CONV_RAW, GAIN_COEF, OFFSET_COEF;
  logic REG_RVALID, CONV_DONE, SEQ_ACTIVE, AINBUF_P, DATA_VALID;
  logic [2:0] ACTIVE_CH, DATA_CH;
  logic [4:0] MUX_POS, MUX_NEG;
  logic [1:0] REF_SEL;
  logic [23:0] DATA_OUT;
  logic POLARITY;
  int num_errors = 0, n_compared = 0;
  logic [2:0] sq [3] = '{3'h1, 3'h3, 3'h6};
  logic [4:0] mp [3] = '{5'h00, 5'h04, 5'h08};
  logic [4:0] mn [3] = '{5'h01, 5'h08, 5'h04};
  logic [1:0] rs [3] = '{2'h1, 2'h2, 2'h2};
  logic [15:0] FILTER_CFG;
  logic [15:0] fc [3] = '{16'h0500, 16'h0123, 16'h0123};
  // Partner raw results 0x123456 stepping by 0x9A5A3B, coded by each slot's polarity
  logic [23:0] dq [6] = '{24'h92_3456, 24'h00_0000, 24'h8D_D198, 24'h61_4307, 24'hF7_3A84,
    24'h2B_EEFA};
  acss_sequencer acss_sequencer_i (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .CONV_DONE(CONV_DONE), .CONV_RAW(CONV_RAW), .SEQ_ACTIVE(SEQ_ACTIVE), .ACTIVE_CH(ACTIVE_CH),
    .MUX_POS(MUX_POS), .MUX_NEG(MUX_NEG), .POLARITY(POLARITY), .REFBUF_P(), .REFBUF_N(),
    .AINBUF_P(AINBUF_P), .AINBUF_N(), .BURNOUT(), .REF_SEL(REF_SEL), .FILTER_CFG(FILTER_CFG),
    .GAIN_COEF(GAIN_COEF), .OFFSET_COEF(OFFSET_COEF), .SUPPRESS_DELAY(), .SINGLE_CYCLE(),
    .DELAY_SEL(), .CLOCK_SEL(), .DATA_VALID(DATA_VALID), .DATA_CH(DATA_CH), .DATA_OUT(DATA_OUT));
  acss_filter_model acss_filter_model_i (.clk(CLK), .rst_n(RST_N), .run(run), .gap(4'h4),
    .done(CONV_DONE), .raw(CONV_RAW));
  initial begin
    forever #10 CLK = ~CLK;
  end
  task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge CLK) #1 REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge CLK) #1 REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    @(posedge CLK) #1 REG_RD = 1'b1;
    REG_ADDR = a;
    @(posedge CLK) #1 REG_RD = 1'b0;
    check("rvalid", {23'h0, REG_RVALID}, 24'h00_0001);
    check("rdata", REG_RDATA, exp);
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog against a hung wait
  initial begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    stop_test;
  end
  initial begin
    int k;
    repeat (5) @(posedge CLK);
    #1 RST_N = 1'b1;
    rd(8'h01, 24'h00_2000);
    rd(8'h20, 24'h00_1000);
    check("ref_sel", {22'h0, REF_SEL}, 24'h00_0000);
    rd(8'h38, 24'h50_0000);
    rd(8'h37, 24'h80_0000);
    check("gain", GAIN_COEF, 24'h50_0000);
    check("offset", OFFSET_COEF, 24'h80_0000);
    rd(8'h07, 24'h00_0000);
    wr(8'h01, 24'h00_FFFF);
    rd(8'h01, 24'h00_677C);
    wr(8'h01, 24'h00_0000);
    wr(8'h27, 24'h00_FFFF);
    rd(8'h27, 24'h00_1FB0);
    wr(8'h17, 24'h00_FFFF);
    rd(8'h17, 24'h00_F3FF);
    wr(8'h17, 24'h00_0000);
    // Two setups shared by three slots, one single-ended on a common pin
    wr(8'h21, 24'h00_1010);
    wr(8'h22, 24'h00_0320);
    wr(8'h2A, 24'h00_0123);
    wr(8'h11, 24'h00_9001);
    wr(8'h13, 24'h00_A088);
    wr(8'h16, 24'h00_A104);
    run = 1'b1;
    for (int i = 0; i < 6; i++) begin
      k = 0;
      while (DATA_VALID !== 1'b1 && k < 100) begin
        @(posedge CLK) #1 k++;
      end
      check("data_valid", {23'h0, DATA_VALID}, 24'h00_0001);
      check("data_ch", {21'h0, DATA_CH}, {21'h0, sq[i % 3]});
      check("data_out", DATA_OUT, dq[i]);
      @(posedge CLK) #1;
      // Next slot's crosspoint and setup are applied
      check("active_ch", {21'h0, ACTIVE_CH}, {21'h0, sq[(i + 1) % 3]});
      check("mux_pos", {19'h0, MUX_POS}, {19'h0, mp[(i + 1) % 3]});
      check("mux_neg", {19'h0, MUX_NEG}, {19'h0, mn[(i + 1) % 3]});
      check("ref_sel", {22'h0, REF_SEL}, {22'h0, rs[(i + 1) % 3]});
      check("ainbuf", {23'h0, AINBUF_P}, {23'h0, rs[(i + 1) % 3][1]});
      check("polarity", {23'h0, POLARITY}, {23'h0, rs[(i + 1) % 3][0]});
      check("filter_cfg", {8'h00, FILTER_CFG}, {8'h00, fc[(i + 1) % 3]});
    end
    stop_test;
  end
endmodule
`default_nettype wire

//--- verilog/acss_defines.vh
// Register offsets, field positions, reset values and masks of the channel/setup sequencer
`ifndef ACSS_DEFINES_VH
`define ACSS_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACSS_OFF_MODE 8'h01
`define ACSS_OFF_CH0 8'h10
`define ACSS_OFF_SETUP0 8'h20
`define ACSS_OFF_FILT0 8'h28
`define ACSS_OFF_OFFS0 8'h30
`define ACSS_OFF_GAIN_COEFFICIENT_ZERO 8'h38
// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define ACSS_RST_MODE 16'h2000
`define ACSS_RST_SETUP 16'h1000
`define ACSS_RST_FILT 16'h0500
`define ACSS_RST_CH 16'h0000
`define ACSS_RST_OFFS 24'h80_0000
`define ACSS_MSK_MODE 16'h677C
`define ACSS_MSK_SETUP 16'h1FB0
`define ACSS_MSK_FILT 16'h8F7F
`define ACSS_MSK_CH 16'hF3FF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACSS_MODE_SUPPRESS 14
`define ACSS_MODE_SINGCYC 13
`define ACSS_MODE_DLY_HI 10
`define ACSS_MODE_DLY_LO 8
`define ACSS_MODE_CONV_HI 6
`define ACSS_MODE_CONV_LO 4
`define ACSS_MODE_CLK_HI 3
`define ACSS_MODE_CLK_LO 2
`define ACSS_CONV_CONTINUOUS 3'h0
`define ACSS_CH_EN 15
`define ACSS_CH_SETUP_HI 14
`define ACSS_CH_SETUP_LO 12
`define ACSS_CH_POS_HI 9
`define ACSS_CH_POS_LO 5
`define ACSS_CH_NEG_HI 4
`define ACSS_CH_NEG_LO 0
`define ACSS_SU_POLARITY 12
`define ACSS_SU_REFBUF_P 11
`define ACSS_SU_REFBUF_N 10
`define ACSS_SU_AINBUF_P 9
`define ACSS_SU_AINBUF_N 8
`define ACSS_SU_BURNOUT 7
`define ACSS_SU_REF_HI 5
`define ACSS_SU_REF_LO 4
`define ACSS_REF_EXT1 2'h0
`define ACSS_REF_EXT2 2'h1
`define ACSS_REF_SUPPLY 2'h2
`endif

//--- verilog/acss_next_ch.v
// Picks the next enabled channel above the current one, wrapping to the lowest
`timescale 1ns/1ns
`default_nettype none
module acss_next_ch #(
  parameter NCH = 8,
  parameter CW = 3
) (
  input wire [NCH-1:0] en,
  input wire [CW-1:0] cur,
  output reg [CW-1:0] nxt,
  output reg any
);
  integer i;
  reg [CW-1:0] idx;

  // Search downward so the nearest channel in ascending order wins
  always @* begin
    nxt = cur;
    any = |en;
    idx = cur;
    for (i = NCH - 1; i >= 1; i = i - 1) begin
      idx = cur + i[CW-1:0];
      if (en[idx]) begin
        nxt = idx;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/acss_sequencer.v
// Channel slots, setups and ascending channel sequencer of a multiplexed converter
`timescale 1ns/1ns
`default_nettype none
`include "acss_defines.vh"
//
// Behaviour
// - Eight setups exist; each channel uses one, setups may be shared.
// - Channel register MSB enables that channel's input pair for conversion.
// - Enabled channels convert in ascending order, then wrap to lowest enabled.
// - Up to eight channel slots enabled together, each with its own pair.
// - Any of nine inputs may route to positive or negative side.
// - Single-ended use converts input minus a freely chosen common pin.
// - Input buffers bypassable; mux then drives converter input directly.
// - Setup bits 5:4 choose reference one, reference two or supply.
// - Reference select resets to the first external reference pair.
// - Gain and offset optional; defaults hold when never written.
// - Setup word zero at 0x20, reset 0x1000, with documented bit fields.
// - Mode word at 0x01, reset 0x2000, with documented bit fields.
// - Each channel register selects which of eight setups it uses.
// - Bipolar results offset binary, unipolar results straight binary.
module acss_sequencer #(
  parameter NCH = 8,
  parameter CW = 3,
  parameter DW = 24,
  parameter [23:0] GAIN_DEFAULT = 24'h50_0000
) (
  input wire CLK,
  input wire RST_N,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [23:0] REG_WDATA,
  output reg [23:0] REG_RDATA,
  output reg REG_RVALID,
  input wire CONV_DONE,
  input wire [DW-1:0] CONV_RAW,
  output reg SEQ_ACTIVE,
  output reg [CW-1:0] ACTIVE_CH,
  output reg [4:0] MUX_POS,
  output reg [4:0] MUX_NEG,
  output reg POLARITY,
  output reg REFBUF_P,
  output reg REFBUF_N,
  output reg AINBUF_P,
  output reg AINBUF_N,
  output reg BURNOUT,
  output reg [1:0] REF_SEL,
  output reg [15:0] FILTER_CFG,
  output reg [23:0] GAIN_COEF,
  output reg [23:0] OFFSET_COEF,
  output reg SUPPRESS_DELAY,
  output reg SINGLE_CYCLE,
  output reg [2:0] DELAY_SEL,
  output reg [1:0] CLOCK_SEL,
  output reg DATA_VALID,
  output reg [CW-1:0] DATA_CH,
  output reg [DW-1:0] DATA_OUT
);
  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [15:0] mode_r;
  reg [15:0] ch_r [0:NCH-1];
  reg [15:0] setup_r [0:NCH-1];
  reg [15:0] filt_r [0:NCH-1];
  reg [23:0] offs_r [0:NCH-1];
  reg [23:0] gain_r [0:NCH-1];
  reg [CW-1:0] cur_r;
  wire [NCH-1:0] ch_en;
  wire [CW-1:0] nxt_ch;
  wire any_en;
  wire [CW-1:0] ridx;
  wire [CW-1:0] cur_setup;
  wire running;

  assign ridx = REG_ADDR[CW-1:0];

  // Mode word, writable bits only
  // mode word storage
  always @(posedge CLK) begin
    if (!RST_N) begin
      mode_r <= `ACSS_RST_MODE;
    end else if (REG_WR && REG_ADDR == `ACSS_OFF_MODE) begin
      mode_r <= REG_WDATA[15:0] & `ACSS_MSK_MODE;
    end
  end

  // Per-slot channel and setup registers
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : slot
      assign ch_en[g] = ch_r[g][`ACSS_CH_EN];
      always @(posedge CLK) begin
        if (!RST_N) begin
          ch_r[g] <= `ACSS_RST_CH;
          setup_r[g] <= `ACSS_RST_SETUP;
          filt_r[g] <= `ACSS_RST_FILT;
          offs_r[g] <= `ACSS_RST_OFFS;
          gain_r[g] <= GAIN_DEFAULT;
        end else if (REG_WR) begin
          if (REG_ADDR == `ACSS_OFF_CH0 + g) begin
            ch_r[g] <= REG_WDATA[15:0] & `ACSS_MSK_CH;
          end
          if (REG_ADDR == `ACSS_OFF_SETUP0 + g) begin
            setup_r[g] <= REG_WDATA[15:0] & `ACSS_MSK_SETUP;
          end
          if (REG_ADDR == `ACSS_OFF_FILT0 + g) begin
            filt_r[g] <= REG_WDATA[15:0] & `ACSS_MSK_FILT;
          end
          if (REG_ADDR == `ACSS_OFF_OFFS0 + g) begin
            offs_r[g] <= REG_WDATA;
          end
          if (REG_ADDR == `ACSS_OFF_GAIN_COEFFICIENT_ZERO + g) begin
            gain_r[g] <= REG_WDATA;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Registered read data, unmapped offsets read zero
  always @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 24'h00_0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        if (REG_ADDR == `ACSS_OFF_MODE) begin
          REG_RDATA <= {8'h00, mode_r};
        end else if (REG_ADDR[7:3] == `ACSS_OFF_CH0 >> 3) begin
          REG_RDATA <= {8'h00, ch_r[ridx]};
        end else if (REG_ADDR[7:3] == `ACSS_OFF_SETUP0 >> 3) begin
          REG_RDATA <= {8'h00, setup_r[ridx]};
        end else if (REG_ADDR[7:3] == `ACSS_OFF_FILT0 >> 3) begin
          REG_RDATA <= {8'h00, filt_r[ridx]};
        end else if (REG_ADDR[7:3] == `ACSS_OFF_OFFS0 >> 3) begin
          REG_RDATA <= offs_r[ridx];
        end else if (REG_ADDR[7:3] == `ACSS_OFF_GAIN_COEFFICIENT_ZERO >> 3) begin
          REG_RDATA <= gain_r[ridx];
        end else begin
          REG_RDATA <= 24'h00_0000;
        end
      end
    end
  end

  // ----------------------------------------
  // Channel sequencer
  // ----------------------------------------
  acss_next_ch #(
    .NCH(NCH),
    .CW(CW)
  ) u_next (
    .en(ch_en),
    .cur(cur_r),
    .nxt(nxt_ch),
    .any(any_en)
  );

  assign running = any_en &&
    (mode_r[`ACSS_MODE_CONV_HI:`ACSS_MODE_CONV_LO] == `ACSS_CONV_CONTINUOUS);

  // Step on each finished conversion, or leave a slot that was disabled
  // ascending wrap order
  always @(posedge CLK) begin
    if (!RST_N) begin
      cur_r <= {CW{1'b0}};
    end else if (any_en && (!ch_en[cur_r] || (running && CONV_DONE))) begin
      cur_r <= nxt_ch;
    end
  end

  assign cur_setup = ch_r[cur_r][`ACSS_CH_SETUP_HI:`ACSS_CH_SETUP_LO];

  // Drive analog and filter controls from the current slot's setup
  // per-channel setup applied
  always @(posedge CLK) begin
    if (!RST_N) begin
      SEQ_ACTIVE <= 1'b0;
      ACTIVE_CH <= {CW{1'b0}};
      MUX_POS <= 5'h00;
      MUX_NEG <= 5'h00;
      POLARITY <= 1'b1;
      REFBUF_P <= 1'b0;
      REFBUF_N <= 1'b0;
      AINBUF_P <= 1'b0;
      AINBUF_N <= 1'b0;
      BURNOUT <= 1'b0;
      REF_SEL <= `ACSS_REF_EXT1;
      FILTER_CFG <= `ACSS_RST_FILT;
      GAIN_COEF <= GAIN_DEFAULT;
      OFFSET_COEF <= `ACSS_RST_OFFS;
      SUPPRESS_DELAY <= 1'b0;
      SINGLE_CYCLE <= 1'b1;
      DELAY_SEL <= 3'h0;
      CLOCK_SEL <= 2'h0;
    end else begin
      SEQ_ACTIVE <= running && ch_en[cur_r];
      ACTIVE_CH <= cur_r;
      MUX_POS <= ch_r[cur_r][`ACSS_CH_POS_HI:`ACSS_CH_POS_LO];
      MUX_NEG <= ch_r[cur_r][`ACSS_CH_NEG_HI:`ACSS_CH_NEG_LO];
      POLARITY <= setup_r[cur_setup][`ACSS_SU_POLARITY];
      REFBUF_P <= setup_r[cur_setup][`ACSS_SU_REFBUF_P];
      REFBUF_N <= setup_r[cur_setup][`ACSS_SU_REFBUF_N];
      AINBUF_P <= setup_r[cur_setup][`ACSS_SU_AINBUF_P];
      AINBUF_N <= setup_r[cur_setup][`ACSS_SU_AINBUF_N];
      BURNOUT <= setup_r[cur_setup][`ACSS_SU_BURNOUT];
      REF_SEL <= setup_r[cur_setup][`ACSS_SU_REF_HI:`ACSS_SU_REF_LO];
      FILTER_CFG <= filt_r[cur_setup];
      GAIN_COEF <= gain_r[cur_setup];
      OFFSET_COEF <= offs_r[cur_setup];
      SUPPRESS_DELAY <= mode_r[`ACSS_MODE_SUPPRESS];
      SINGLE_CYCLE <= mode_r[`ACSS_MODE_SINGCYC];
      DELAY_SEL <= mode_r[`ACSS_MODE_DLY_HI:`ACSS_MODE_DLY_LO];
      CLOCK_SEL <= mode_r[`ACSS_MODE_CLK_HI:`ACSS_MODE_CLK_LO];
    end
  end

  // ----------------------------------------
  // Result coding
  // ----------------------------------------
  // Signed raw result to offset binary, or clamped straight binary
  // polarity dependent coding
  always @(posedge CLK) begin
    if (!RST_N) begin
      DATA_VALID <= 1'b0;
      DATA_CH <= {CW{1'b0}};
      DATA_OUT <= {DW{1'b0}};
    end else begin
      DATA_VALID <= running && ch_en[cur_r] && CONV_DONE;
      if (running && ch_en[cur_r] && CONV_DONE) begin
        DATA_CH <= cur_r;
        if (setup_r[cur_setup][`ACSS_SU_POLARITY]) begin
          DATA_OUT <= {~CONV_RAW[DW-1], CONV_RAW[DW-2:0]};
        end else if (CONV_RAW[DW-1]) begin
          DATA_OUT <= {DW{1'b0}};
        end else begin
          DATA_OUT <= {CONV_RAW[DW-2:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire
